// ### strap_pkg.sv
// Shared constants for the reset strap and status pin block
package strap_pkg;
    localparam int            NUM_PORTS          = 4;
    // Strap encodings
    localparam logic          SERIAL_IF_I2C      = 1'h1;
    localparam logic          SERIAL_IF_SMBUS    = 1'h0;
    localparam logic          PWR_MGMT_ENABLED   = 1'h0;
    localparam logic          POLARITY_HIGH      = 1'h1;
    // Slave address field positions
    localparam int            SLAVE_ADDR_BIT1    = 1;
    localparam int            SLAVE_ADDR_BIT2    = 2;
    localparam int            SLAVE_ADDR_WIDTH   = 7;
    // Default fixed slave address bits (bits 1 and 2 come from straps)
    localparam logic [6:0]    SLAVE_ADDR_BASE    = 7'h44;
    // Cycles after reset release before straps are captured
    localparam int            CAPTURE_DELAY_CYC  = 2;
    localparam logic [1:0]    CAPTURE_DELAY_LAST = 2'h1;
    // Reset values
    localparam logic          RST_SERIAL_IF      = 1'h1;
    localparam logic          RST_PWR_DISABLE    = 1'h0;
    localparam logic          RST_POLARITY       = 1'h1;
endpackage

// ### strap_capture.sv
// Capture of the strap levels once after reset release
`timescale 1ns/1ps
module strap_capture
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Pin levels
    input  wire logic       serial_if_select_in,
    input  wire logic       power_mgmt_disable_in,
    input  wire logic       power_ctl_polarity_in,
    input  wire logic       slave_addr_bit2_in,
    // Latched values
    output logic            straps_valid,
    output logic            serial_if_select_strap,
    output logic            power_mgmt_disable_strap,
    output logic            power_ctl_polarity_strap,
    output logic            slave_addr_bit1_strap,
    output logic            slave_addr_bit2_strap
);
    logic [1:0] wait_ff;
    logic [1:0] nxt_wait;
    logic       done_ff;
    logic       nxt_done;
    logic [4:0] strap_ff;
    logic [4:0] nxt_strap;

    // The pins are driven by the output side only after done_ff, so the
    // strap resistors are read before anything drives them.
    always_comb
    begin
        nxt_wait  = wait_ff;
        nxt_done  = done_ff;
        nxt_strap = strap_ff;
        if (!done_ff)
        begin
            if (wait_ff == strap_pkg::CAPTURE_DELAY_LAST)
            begin
                nxt_done  = 1'b1;
                nxt_strap = {slave_addr_bit2_in, power_mgmt_disable_in, power_ctl_polarity_in,
                             power_mgmt_disable_in, serial_if_select_in};
            end
            else
            begin
                nxt_wait = wait_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_ff  <= 2'h0;
            done_ff  <= 1'b0;
            strap_ff <= {1'b0, 1'b0, strap_pkg::RST_POLARITY, strap_pkg::RST_PWR_DISABLE,
                         strap_pkg::RST_SERIAL_IF};
        end
        else
        begin
            wait_ff  <= nxt_wait;
            done_ff  <= nxt_done;
            strap_ff <= nxt_strap;
        end
    end

    assign straps_valid             = done_ff;
    assign serial_if_select_strap   = strap_ff[0];
    assign power_mgmt_disable_strap = strap_ff[1];
    assign power_ctl_polarity_strap = strap_ff[2];
    assign slave_addr_bit1_strap    = strap_ff[3];
    assign slave_addr_bit2_strap    = strap_ff[4];
endmodule

// ### reset_strap_status_pins.sv
// Reset strap capture and post-reset status output muxing for shared pins
`timescale 1ns/1ps
module reset_strap_status_pins
#(
    parameter int NUM_PORTS = strap_pkg::NUM_PORTS
)
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Shared pin: interface select strap / suspend status
    input  wire logic                  serial_if_select_in,
    output logic                       serial_if_select_out,
    output logic                       serial_if_select_oe,
    // Shared pin: power management strap / connection status
    input  wire logic                  power_mgmt_disable_in,
    output logic                       power_mgmt_disable_out,
    output logic                       power_mgmt_disable_oe,
    // Polarity strap and ganged strap pins
    input  wire logic                  power_ctl_polarity_in,
    input  wire logic                  slave_addr_bit2_in,
    // Feature configuration and hub status
    input  wire logic                  suspend_status_en,
    input  wire logic                  connect_status_en,
    input  wire logic                  ss_upstream_suspended,
    input  wire logic                  ss_upstream_connected,
    input  wire logic [NUM_PORTS-1:0]  port_power_request,
    // Per-port power control outputs
    output logic [NUM_PORTS-1:0]       port_power_ctl_out,
    output logic [NUM_PORTS-1:0]       port_power_ctl_oe,
    // Latched configuration to the hub
    output logic                       straps_valid,
    output logic                       i2c_master_mode,
    output logic                       smbus_slave_mode,
    output logic                       power_switching_en,
    output logic                       overcurrent_en,
    output logic [6:0]                 smbus_slave_addr
);
    logic                  valid_w;
    logic                  sel_w;
    logic                  pwr_dis_w;
    logic                  pol_w;
    logic                  a1_w;
    logic                  a2_w;

    logic                  sel_out_ff;
    logic                  nxt_sel_out;
    logic                  sel_oe_ff;
    logic                  nxt_sel_oe;
    logic                  pm_out_ff;
    logic                  nxt_pm_out;
    logic                  pm_oe_ff;
    logic                  nxt_pm_oe;
    logic [NUM_PORTS-1:0]  pwr_ff;
    logic [NUM_PORTS-1:0]  nxt_pwr;
    logic [NUM_PORTS-1:0]  pwr_oe_ff;
    logic [NUM_PORTS-1:0]  nxt_pwr_oe;
    logic                  valid_ff;
    logic                  nxt_valid;
    logic                  i2c_ff;
    logic                  nxt_i2c;
    logic                  smb_ff;
    logic                  nxt_smb;
    logic                  pse_ff;
    logic                  nxt_pse;
    logic [6:0]            addr_ff;
    logic [6:0]            nxt_addr;

    // The straps are read two clocks after reset release, so the board has to
    // keep its strap levels steady for that long; status inputs are free then.
    strap_capture u_capture
    (
        .clk                      (clk),
        .rst_n                    (rst_n),
        .serial_if_select_in      (serial_if_select_in),
        .power_mgmt_disable_in    (power_mgmt_disable_in),
        .power_ctl_polarity_in    (power_ctl_polarity_in),
        .slave_addr_bit2_in       (slave_addr_bit2_in),
        .straps_valid             (valid_w),
        .serial_if_select_strap   (sel_w),
        .power_mgmt_disable_strap (pwr_dis_w),
        .power_ctl_polarity_strap (pol_w),
        .slave_addr_bit1_strap    (a1_w),
        .slave_addr_bit2_strap    (a2_w)
    );

    // Status pins only drive once the straps have been read; driving earlier
    // would feed the status level back in as the strap.
    always_comb
    begin
        nxt_sel_oe  = valid_w && suspend_status_en;
        nxt_sel_out = nxt_sel_oe && ss_upstream_suspended;
        nxt_pm_oe   = valid_w && connect_status_en;
        nxt_pm_out  = nxt_pm_oe && ss_upstream_connected;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_out_ff <= 1'b0;
            sel_oe_ff  <= 1'b0;
            pm_out_ff  <= 1'b0;
            pm_oe_ff   <= 1'b0;
        end
        else
        begin
            sel_out_ff <= nxt_sel_out;
            sel_oe_ff  <= nxt_sel_oe;
            pm_out_ff  <= nxt_pm_out;
            pm_oe_ff   <= nxt_pm_oe;
        end
    end

    // Both mode flags stay low until the capture is done, so the serial side
    // never starts up in a mode taken from a strap that is not yet read.
    always_comb
    begin
        nxt_valid = valid_w;
        nxt_i2c   = valid_w && (sel_w == strap_pkg::SERIAL_IF_I2C);
        nxt_smb   = valid_w && (sel_w == strap_pkg::SERIAL_IF_SMBUS);
        nxt_pse   = valid_w && (pwr_dis_w == strap_pkg::PWR_MGMT_ENABLED);
        nxt_addr  = strap_pkg::SLAVE_ADDR_BASE;
        if (nxt_smb)
        begin
            nxt_addr[strap_pkg::SLAVE_ADDR_BIT1] = a1_w;
            nxt_addr[strap_pkg::SLAVE_ADDR_BIT2] = a2_w;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            valid_ff <= 1'b0;
            i2c_ff   <= 1'b0;
            smb_ff   <= 1'b0;
            pse_ff   <= 1'b0;
            addr_ff  <= strap_pkg::SLAVE_ADDR_BASE;
        end
        else
        begin
            valid_ff <= nxt_valid;
            i2c_ff   <= nxt_i2c;
            smb_ff   <= nxt_smb;
            pse_ff   <= nxt_pse;
            addr_ff  <= nxt_addr;
        end
    end

    // Power outputs stay undriven while the shared charge-enable straps
    // are still being sampled; after that they follow the strapped polarity.
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port
        always_comb
        begin
            nxt_pwr_oe[p] = nxt_pse;
            if (pol_w == strap_pkg::POLARITY_HIGH)
            begin
                nxt_pwr[p] = nxt_pse && port_power_request[p];
            end
            else
            begin
                nxt_pwr[p] = !(nxt_pse && port_power_request[p]);
            end
        end
    end

    // With power management off every port is left floating with oe held low,
    // and its out is parked at the inactive level of the strapped polarity.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_ff    <= '0;
            pwr_oe_ff <= '0;
        end
        else
        begin
            pwr_ff    <= nxt_pwr;
            pwr_oe_ff <= nxt_pwr_oe;
        end
    end

    assign serial_if_select_out   = sel_out_ff;
    assign serial_if_select_oe    = sel_oe_ff;
    assign power_mgmt_disable_out = pm_out_ff;
    assign power_mgmt_disable_oe  = pm_oe_ff;
    assign port_power_ctl_out     = pwr_ff;
    assign port_power_ctl_oe      = pwr_oe_ff;
    assign straps_valid           = valid_ff;
    assign i2c_master_mode        = i2c_ff;
    assign smbus_slave_mode       = smb_ff;
    assign power_switching_en     = pse_ff;
    assign overcurrent_en         = pse_ff;
    assign smbus_slave_addr       = addr_ff;
endmodule

// ### reset_strap_status_pins_checker.sv
// Assertions on the strap capture and shared status pins
`timescale 1ns/1ps
module reset_strap_status_pins_checker
#(
    parameter int NUM_PORTS = 4
)
(
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 rst_n,
    // Shared pins and their controls
    input wire logic                 serial_if_select_out,
    input wire logic                 serial_if_select_oe,
    input wire logic                 power_mgmt_disable_out,
    input wire logic                 power_mgmt_disable_oe,
    input wire logic                 suspend_status_en,
    input wire logic                 connect_status_en,
    input wire logic                 ss_upstream_suspended,
    input wire logic                 ss_upstream_connected,
    input wire logic [NUM_PORTS-1:0] port_power_ctl_oe,
    // Latched configuration
    input wire logic                 straps_valid,
    input wire logic                 i2c_master_mode,
    input wire logic                 smbus_slave_mode,
    input wire logic                 power_switching_en,
    input wire logic                 overcurrent_en,
    input wire logic [6:0]           smbus_slave_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_cap;
        $rose(rst_n) |-> !straps_valid [*3] ##1 straps_valid;
    endproperty
    a_cap: assert property (p_cap) else $error("capture timing wrong");
    property p_mode;
        straps_valid |-> i2c_master_mode != smbus_slave_mode;
    endproperty
    a_mode: assert property (p_mode) else $error("mode outputs clash");
    property p_hold;
        straps_valid |=> straps_valid && $stable(i2c_master_mode)
            && $stable(power_switching_en) && $stable(smbus_slave_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("latched value moved");
    property p_susp;
        serial_if_select_out == (serial_if_select_oe && $past(ss_upstream_suspended));
    endproperty
    a_susp: assert property (p_susp) else $error("suspend pin wrong");
    property p_susp_en;
        straps_valid && $past(straps_valid) |-> serial_if_select_oe == $past(suspend_status_en);
    endproperty
    a_susp_en: assert property (p_susp_en) else $error("suspend enable wrong");
    property p_conn;
        power_mgmt_disable_out == (power_mgmt_disable_oe && $past(ss_upstream_connected));
    endproperty
    a_conn: assert property (p_conn) else $error("connect pin wrong");
    property p_conn_en;
        straps_valid && $past(straps_valid) |-> power_mgmt_disable_oe == $past(connect_status_en);
    endproperty
    a_conn_en: assert property (p_conn_en) else $error("connect enable wrong");
    property p_pwr;
        straps_valid |-> overcurrent_en == power_switching_en
            && port_power_ctl_oe == {NUM_PORTS{power_switching_en}};
    endproperty
    a_pwr: assert property (p_pwr) else $error("power enables wrong");
    property p_addr;
        smbus_slave_mode |-> smbus_slave_addr[6:3] == strap_pkg::SLAVE_ADDR_BASE[6:3]
            && smbus_slave_addr[0] == strap_pkg::SLAVE_ADDR_BASE[0];
    endproperty
    a_addr: assert property (p_addr) else $error("fixed address bits wrong");
    cover property (smbus_slave_mode);
    cover property (serial_if_select_oe && serial_if_select_out);
    cover property (power_switching_en && power_mgmt_disable_oe);
endmodule
bind reset_strap_status_pins reset_strap_status_pins_checker #(.NUM_PORTS(NUM_PORTS)) chk
(
    .clk                    (clk),
    .rst_n                  (rst_n),
    .serial_if_select_out   (serial_if_select_out),
    .serial_if_select_oe    (serial_if_select_oe),
    .power_mgmt_disable_out (power_mgmt_disable_out),
    .power_mgmt_disable_oe  (power_mgmt_disable_oe),
    .suspend_status_en      (suspend_status_en),
    .connect_status_en      (connect_status_en),
    .ss_upstream_suspended  (ss_upstream_suspended),
    .ss_upstream_connected  (ss_upstream_connected),
    .port_power_ctl_oe      (port_power_ctl_oe),
    .straps_valid           (straps_valid),
    .i2c_master_mode        (i2c_master_mode),
    .smbus_slave_mode       (smbus_slave_mode),
    .power_switching_en     (power_switching_en),
    .overcurrent_en         (overcurrent_en),
    .smbus_slave_addr       (smbus_slave_addr)
);

// ### board_straps.sv
// Board strap resistors and device drive resolved at the two shared pins
`timescale 1ns/1ps
module board_straps
(
    // Strap levels fitted on the board
    input  wire logic strap_if,
    input  wire logic strap_pm,
    // Device side of the shared pins
    input  wire logic if_out,
    input  wire logic if_oe,
    input  wire logic pm_out,
    input  wire logic pm_oe,
    // Levels seen at the pins
    output logic      pin_if,
    output logic      pin_pm
);
    // The resistor only wins while the device has let go of the pin
    assign pin_if = if_oe ? if_out : strap_if;
    // Charging boards fit the switching strap low; the bench picks the level
    assign pin_pm = pm_oe ? pm_out : strap_pm;
endmodule

// ### test_reset_strap_status_pins.sv
// Self-checking bench for the strap capture and status pins
`timescale 1ns/1ps
module test_reset_strap_status_pins;
    logic       clk = 1'h0;
    logic       rst_n = 1'h0;
    logic [3:0] strap = 4'h0;
    logic [3:0] s;
    logic [7:0] stim = 8'h00;
    logic [7:0] prev;
    logic       pin_if, pin_pm;
    logic       serial_if_select_out, serial_if_select_oe;
    logic       power_mgmt_disable_out, power_mgmt_disable_oe;
    logic [3:0] port_power_ctl_out, port_power_ctl_oe;
    logic       straps_valid, i2c_master_mode, smbus_slave_mode;
    logic       power_switching_en, overcurrent_en;
    logic [6:0] smbus_slave_addr;
    int         seed = 97;
    int         errors = 0;
    int         checks_done = 0;
    int         cycles = 0;
    int         waited = 0;
    // Strap bits: 0 interface, 1 power, 2 polarity, 3 address bit 2
    board_straps board (.strap_if(strap[0]), .strap_pm(strap[1]),
        .if_out(serial_if_select_out), .if_oe(serial_if_select_oe),
        .pm_out(power_mgmt_disable_out), .pm_oe(power_mgmt_disable_oe),
        .pin_if(pin_if), .pin_pm(pin_pm));
    reset_strap_status_pins uut
    (
        .clk                    (clk),
        .rst_n                  (rst_n),
        .serial_if_select_in    (pin_if),
        .serial_if_select_out   (serial_if_select_out),
        .serial_if_select_oe    (serial_if_select_oe),
        .power_mgmt_disable_in  (pin_pm),
        .power_mgmt_disable_out (power_mgmt_disable_out),
        .power_mgmt_disable_oe  (power_mgmt_disable_oe),
        .power_ctl_polarity_in  (strap[2]),
        .slave_addr_bit2_in     (strap[3]),
        .suspend_status_en      (stim[0]),
        .connect_status_en      (stim[1]),
        .ss_upstream_suspended  (stim[2]),
        .ss_upstream_connected  (stim[3]),
        .port_power_request     (stim[7:4]),
        .port_power_ctl_out     (port_power_ctl_out),
        .port_power_ctl_oe      (port_power_ctl_oe),
        .straps_valid           (straps_valid),
        .i2c_master_mode        (i2c_master_mode),
        .smbus_slave_mode       (smbus_slave_mode),
        .power_switching_en     (power_switching_en),
        .overcurrent_en         (overcurrent_en),
        .smbus_slave_addr       (smbus_slave_addr)
    );
    always #25 clk = ~clk;
    function automatic logic [3:0] pwr_exp(input logic [3:0] st, input logic [3:0] req);
        if (!st[1])
            return st[2] ? req : ~req;
        return st[2] ? 4'h0 : 4'hf;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errors++;
            tally_and_finish;
        end
    end
    initial
    begin
        // Every strap combination once, then random ones; each pass resets again
        for (int t = 0; t < 24; t++)
        begin
            @(posedge clk);
            rst_n <= 1'h0;
            strap <= (t < 16) ? t[3:0] : 4'($random(seed));
            stim <= 8'($random(seed));
            repeat (6) @(posedge clk);
            rst_n <= 1'h1;
            waited = 0;
            while (straps_valid !== 1'h1 && waited < 10)
            begin
                @(posedge clk);
                #1;
                waited++;
            end
            s = strap;
            check(8'(straps_valid), 8'h01);
            check(8'(waited), 8'(strap_pkg::CAPTURE_DELAY_CYC + 1));
            check(8'(i2c_master_mode), 8'(s[0]));
            check(8'(smbus_slave_mode), 8'(!s[0]));
            check(8'({power_switching_en, overcurrent_en}), {6'h00, {2{!s[1]}}});
            for (int k = 0; k < 12; k++)
            begin
                @(posedge clk);
                strap <= ~s;
                prev = stim;
                stim <= 8'($random(seed));
                #1;
                check(8'(port_power_ctl_out), 8'(pwr_exp(s, prev[7:4])));
                check(8'(port_power_ctl_oe), 8'({4{!s[1]}}));
                check(8'({serial_if_select_oe, serial_if_select_out}),
                      8'({prev[0], prev[0] & prev[2]}));
                check(8'({power_mgmt_disable_oe, power_mgmt_disable_out}),
                      8'({prev[1], prev[1] & prev[3]}));
            end
            check(8'(i2c_master_mode), 8'(s[0]));
            if (!s[0])
                check(8'(smbus_slave_addr),
                      8'({strap_pkg::SLAVE_ADDR_BASE[6:3], s[3], s[1], 1'h0}));
            else
                check(8'(smbus_slave_addr), 8'(strap_pkg::SLAVE_ADDR_BASE));
            $display("test %0d done", t);
        end
        tally_and_finish;
    end
endmodule
